// ### core/fsc_compressor.sv
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "fsc_consts.svh"

// Notes on behaviour
// R1 - the first batch event after compression starts writes the current sample uncompressed.
// R2 - after that each entry is a triple-diff word, a pair-diff word or a plain word two slots old.
// R3 - a plain word two slots old carries all three axes at full width.
// R4 - each difference is taken against the sample immediately before it.
// R5 - a window of three samples is held and a pair-diff word holds latencies two and one.
// R6 - plain words one slot old appear only on a configuration change.
// R7 - a configuration change writes a change word, a timestamp, then all pending samples plain.
// R8 - after the flush compression resumes once the window refills.
// R9 - the forced plain period field selects never, 8, 16 or 32 batch events.
// R10 - the host reinitialises the compressor whenever the queue enters bypass mode.
// R11 - with per-slot timestamping a timestamp word is written in every slot.
// R12 - above 128 LSB a sample goes plain, 16 to 128 pairs, below 16 triples.
// R13 - a pair-diff word holds six signed bytes, x y z of latency two then latency one.
// R14 - a triple-diff word holds latencies two, one, zero at 15:0, 31:16, 47:32, each as 5-bit x y z diffs at 4:0, 9:5, 14:10.
// R15 - compression runs only with both feature and runtime enables set.
// R16 - with compression off every sample is written plain in its own slot.
module fsc_compressor
  import fsc_pkg::*;
#(
  parameter int AXIS_W = 16
)(
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              batch_event,
  input  wire logic [AXIS_W-1:0] sample_x,
  input  wire logic [AXIS_W-1:0] sample_y,
  input  wire logic [AXIS_W-1:0] sample_z,
  input  wire logic              cfg_change,
  input  wire logic [15:0]       timestamp,
  output logic                   word_valid,
  output fsc_tag_t               word_tag,
  output logic      [47:0]       word_data
);

  // the packing below assumes 16-bit axes, so other widths are refused at elaboration
  if (AXIS_W != 16)
  begin
    $error("fsc_compressor serves 16-bit axes only");
  end

  localparam int SW = 3 * AXIS_W;

  logic       compress_feature_enable;
  logic       runtime_compress_enable;
  logic       ts_per_slot;
  logic [1:0] forced_plain_period;
  logic       compress_reinit;
  logic       active;
  logic       active_d;
  logic       cfg_pend;
  logic [1:0] fill;
  logic [5:0] slot_count;
  logic [SW-1:0] win [3];
  logic [SW-1:0] ref_s;
  // output queue for one slot: up to change, timestamp, three samples
  fsc_tag_t   q_tag [5];
  logic [47:0] q_dat [5];
  logic [2:0] q_len;
  logic [2:0] q_idx;
  fsc_state_t state;

  assign active = compress_feature_enable & runtime_compress_enable; // R15

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      compress_feature_enable <= 1'b0;
      runtime_compress_enable <= 1'b0;
      ts_per_slot             <= 1'b0;
      forced_plain_period     <= 2'b00;
    end
    else if (reg_wr && reg_addr == `FSC_ADDR_CTRL)
    begin
      compress_feature_enable <= reg_wdata[`FSC_CTRL_FEAT_BIT];
      runtime_compress_enable <= reg_wdata[`FSC_CTRL_RT_BIT];
      ts_per_slot             <= reg_wdata[`FSC_CTRL_TS_BIT];
      forced_plain_period     <= reg_wdata[`FSC_CTRL_RATE_LSB +: 2];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      compress_reinit <= 1'b0;
    else
      compress_reinit <= reg_wr && reg_addr == `FSC_ADDR_INIT && reg_wdata[0]; // R10
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `FSC_ADDR_CTRL:   reg_rdata <= {3'h0, forced_plain_period, ts_per_slot,
                                        runtime_compress_enable, compress_feature_enable};
        `FSC_ADDR_STATUS: reg_rdata <= {cfg_pend, state == FSC_ST_EMIT, fill, 1'b0, q_idx};
        default:          reg_rdata <= 8'h00;
      endcase
    end
  end

  // dropping out of compression (either enable cleared) counts as a configuration change; set wins over the slot consume
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_pend <= 1'b0;
      active_d <= 1'b0;
    end
    else
    begin
      active_d <= active;
      if (cfg_change || (active_d && !active))
        cfg_pend <= 1'b1;
      else if (batch_event && state == FSC_ST_IDLE && !compress_reinit)
        cfg_pend <= 1'b0;
    end
  end

  function automatic logic [AXIS_W-1:0] adiff(input logic [AXIS_W-1:0] a,
                                               input logic [AXIS_W-1:0] b);
    logic [AXIS_W-1:0] d;
    d = a - b;
    adiff = d[AXIS_W-1] ? -d : d;
  endfunction

  function automatic logic [AXIS_W-1:0] maxdiff(input logic [SW-1:0] a,
                                                 input logic [SW-1:0] b);
    logic [AXIS_W-1:0] m;
    m = '0;
    for (int k = 0; k < 3; k++)
      if (adiff(a[k*AXIS_W +: AXIS_W], b[k*AXIS_W +: AXIS_W]) > m)
        m = adiff(a[k*AXIS_W +: AXIS_W], b[k*AXIS_W +: AXIS_W]);
    maxdiff = m;
  endfunction

  function automatic logic [14:0] pack5(input logic [SW-1:0] a, input logic [SW-1:0] b);
    logic [14:0] r;
    r = 15'h0000;
    for (int k = 0; k < 3; k++)
      r[k*5 +: 5] = 5'(a[k*AXIS_W +: AXIS_W] - b[k*AXIS_W +: AXIS_W]);
    pack5 = r;
  endfunction

  function automatic logic [23:0] pack8(input logic [SW-1:0] a, input logic [SW-1:0] b);
    logic [23:0] r;
    r = 24'h000000;
    for (int k = 0; k < 3; k++)
      r[k*8 +: 8] = 8'(a[k*AXIS_W +: AXIS_W] - b[k*AXIS_W +: AXIS_W]);
    pack8 = r;
  endfunction

  logic [5:0] period;
  logic       force_plain;
  logic [SW-1:0] cur;
  logic [AXIS_W-1:0] d2;
  logic [AXIS_W-1:0] d1;
  logic [AXIS_W-1:0] d0;

  always_comb
  begin
    case (forced_plain_period) // R9
      2'b01:   period = `FSC_PERIOD_8;
      2'b10:   period = `FSC_PERIOD_16;
      2'b11:   period = `FSC_PERIOD_32;
      default: period = 6'd0;
    endcase
    force_plain = (period != 6'd0) && (slot_count >= period - 6'd1);
    cur = {sample_z, sample_y, sample_x};
    d2  = maxdiff(win[0], ref_s); // R4
    d1  = maxdiff(win[1], win[0]);
    d0  = maxdiff(cur, win[1]);
  end

  // slot processing: builds the words of one batch event, then drains them one a cycle
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state      <= FSC_ST_IDLE;
      fill       <= 2'd0;
      slot_count <= 6'd0;
      q_len      <= 3'd0;
      q_idx      <= 3'd0;
      ref_s      <= '0;
      for (int k = 0; k < 3; k++)
        win[k] <= '0;
      for (int k = 0; k < 5; k++)
      begin
        q_tag[k] <= FSC_TAG_PLAIN;
        q_dat[k] <= 48'h0;
      end
    end
    else if (compress_reinit)
    begin
      state <= FSC_ST_IDLE;
      fill  <= 2'd0;
      slot_count <= 6'd0;
    end
    else if (state == FSC_ST_EMIT)
    begin
      if (q_idx == q_len - 3'd1)
        state <= FSC_ST_IDLE;
      q_idx <= q_idx + 3'd1;
    end
    else if (batch_event)
    begin
      automatic int n = 0;
      q_idx <= 3'd0;
      slot_count <= slot_count + 6'd1;
      if (cfg_pend)
      begin
        q_tag[n] <= FSC_TAG_CFG_CHANGE; // R7
        q_dat[n] <= 48'h0;
        n++;
      end
      if (cfg_pend || ts_per_slot) // R11
      begin
        q_tag[n] <= FSC_TAG_TIMESTAMP;
        q_dat[n] <= {32'h0, timestamp};
        n++;
      end
      if (!active || fill == 2'd0 || cfg_pend)
      begin
        // pending samples are flushed whatever the enables now say; an event on the first edge after a disable, before cfg_pend is set, loses them
        if (cfg_pend && fill == 2'd2) // R7 R6
        begin
          q_tag[n] <= FSC_TAG_PLAIN_T2;
          q_dat[n] <= win[0];
          n++;
        end
        if (cfg_pend && (fill == 2'd1 || fill == 2'd2)) // R6
        begin
          q_tag[n] <= FSC_TAG_PLAIN_T1;
          q_dat[n] <= win[1];
          n++;
        end
        q_tag[n] <= FSC_TAG_PLAIN; // R1 R16
        q_dat[n] <= cur;
        n++;
        ref_s      <= cur;
        slot_count <= 6'd0;
        // fill 3: reference held and window empty, so the written sample is not sent again
        fill <= active ? 2'd3 : 2'd0; // R8
      end
      else if (fill == 2'd3)
      begin
        win[1] <= cur;
        fill   <= 2'd1; // R8
      end
      else if (fill == 2'd1)
      begin
        win[0] <= win[1];
        win[1] <= cur;
        fill   <= 2'd2; // R5
      end
      else if (force_plain || d2 > `FSC_THR_PAIR) // R12
      begin
        q_tag[n] <= FSC_TAG_PLAIN_T2; // R2 R3
        q_dat[n] <= win[0];
        n++;
        ref_s      <= win[0];
        slot_count <= 6'd0; // R9
        win[0] <= win[1];
        win[1] <= cur;
      end
      else if (d2 < `FSC_THR_TRIPLE && d1 < `FSC_THR_TRIPLE && d0 < `FSC_THR_TRIPLE)
      begin
        q_tag[n] <= FSC_TAG_TRIPLE_DIFF; // R2 R14
        q_dat[n] <= {1'b0, pack5(cur, win[1]), 1'b0, pack5(win[1], win[0]),
                     1'b0, pack5(win[0], ref_s)};
        n++;
        ref_s <= cur;
        // window empties; the newest sample becomes the reference
        fill  <= 2'd3;
      end
      else if (d1 <= `FSC_THR_PAIR)
      begin
        q_tag[n] <= FSC_TAG_PAIR_DIFF; // R2 R13 R5
        q_dat[n] <= {pack8(win[1], win[0]), pack8(win[0], ref_s)};
        n++;
        ref_s  <= win[1];
        win[1] <= cur;
        fill   <= 2'd1;
      end
      else
      begin
        q_tag[n] <= FSC_TAG_PLAIN_T2;
        q_dat[n] <= win[0];
        n++;
        ref_s      <= win[0];
        slot_count <= 6'd0;
        win[0] <= win[1];
        win[1] <= cur;
      end
      q_len <= 3'(n);
      if (n != 0)
        state <= FSC_ST_EMIT;
    end
  end

  always_comb
  begin
    word_valid = (state == FSC_ST_EMIT);
    word_tag   = q_tag[q_idx];
    word_data  = q_dat[q_idx];
  end

  AST_FIRST_PLAIN: assert property (@(posedge ref_clk) disable iff (!rst_b) // R1
    state == FSC_ST_IDLE && batch_event && !compress_reinit && active && !cfg_pend
    && !ts_per_slot && fill == 2'd0
    |=> word_valid && word_tag == FSC_TAG_PLAIN && word_data == $past(cur))
    else $error("first word after start is not plain");
  AST_NO_T1_STEADY: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
    word_valid && word_tag == FSC_TAG_PLAIN_T1 |-> q_tag[0] == FSC_TAG_CFG_CHANGE)
    else $error("previous-slot word without configuration change");
  AST_CFG_ORDER: assert property (@(posedge ref_clk) disable iff (!rst_b) // R7
    word_valid && word_tag == FSC_TAG_CFG_CHANGE |=> word_valid && word_tag == FSC_TAG_TIMESTAMP)
    else $error("configuration word not followed by timestamp");
  AST_OFF_PLAIN: assert property (@(posedge ref_clk) disable iff (!rst_b) // R16
    word_valid && !active && !active_d && word_tag != FSC_TAG_TIMESTAMP
    && word_tag != FSC_TAG_CFG_CHANGE && q_tag[0] != FSC_TAG_CFG_CHANGE
    |-> word_tag == FSC_TAG_PLAIN)
    else $error("compressed word while compression off");
  AST_TS_SLOT: assert property (@(posedge ref_clk) disable iff (!rst_b) // R11
    state == FSC_ST_IDLE && batch_event && ts_per_slot && !compress_reinit
    |=> word_valid && (word_tag == FSC_TAG_TIMESTAMP || word_tag == FSC_TAG_CFG_CHANGE))
    else $error("slot without timestamp");
  AST_QUEUE_BOUND: assert property (@(posedge ref_clk) disable iff (!rst_b) // R7
    word_valid |-> q_idx < q_len && q_len <= 3'd5)
    else $error("queue index out of range");
  AST_FORCE_PERIOD: assert property (@(posedge ref_clk) disable iff (!rst_b) // R9
    state == FSC_ST_IDLE && batch_event && !compress_reinit && active && !cfg_pend
    && !ts_per_slot && fill == 2'd2 && force_plain
    |=> word_valid && word_tag == FSC_TAG_PLAIN_T2)
    else $error("forced plain word missing");
  AST_REINIT: assert property (@(posedge ref_clk) disable iff (!rst_b) // R10
    compress_reinit |=> fill == 2'd0 && state == FSC_ST_IDLE)
    else $error("reinit did not clear window");

  COV_TRIPLE: cover property (@(posedge ref_clk) word_valid && word_tag == FSC_TAG_TRIPLE_DIFF);
  COV_PAIR:   cover property (@(posedge ref_clk) word_valid && word_tag == FSC_TAG_PAIR_DIFF);
  COV_CFG:    cover property (@(posedge ref_clk) word_valid && word_tag == FSC_TAG_PLAIN_T1);
  COV_FLUSH:  cover property (@(posedge ref_clk)
    word_valid && word_tag == FSC_TAG_PLAIN_T2 && q_tag[0] == FSC_TAG_CFG_CHANGE);

endmodule

// ### core/fsc_consts.svh
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH

// register map of the compressor control port
`define FSC_ADDR_CTRL        4'h0
`define FSC_ADDR_STATUS      4'h1
`define FSC_ADDR_INIT        4'h2
// control register fields
`define FSC_CTRL_FEAT_BIT    0
`define FSC_CTRL_RT_BIT      1
`define FSC_CTRL_TS_BIT      2
`define FSC_CTRL_RATE_LSB    3
`define FSC_CTRL_RESET       8'h00
// encoding thresholds in LSB
`define FSC_THR_TRIPLE       16
`define FSC_THR_PAIR         128
// forced plain periods in batch events
`define FSC_PERIOD_8         6'd8
`define FSC_PERIOD_16        6'd16
`define FSC_PERIOD_32        6'd32

`endif

// ### core/fsc_pkg.sv
package fsc_pkg;
  typedef enum logic [2:0] {
    FSC_TAG_PLAIN      = 3'h0,
    FSC_TAG_PLAIN_T1   = 3'h1,
    FSC_TAG_PLAIN_T2   = 3'h2,
    FSC_TAG_PAIR_DIFF  = 3'h3,
    FSC_TAG_TRIPLE_DIFF = 3'h4,
    FSC_TAG_CFG_CHANGE = 3'h5,
    FSC_TAG_TIMESTAMP  = 3'h6
  } fsc_tag_t;

  typedef enum logic [1:0] {
    FSC_ST_IDLE  = 2'b00,
    FSC_ST_EMIT  = 2'b01
  } fsc_state_t;
endpackage

// ### tb/fsc_compressor_tb.sv
`timescale 1ns/1ps
`include "fsc_consts.svh"
module fsc_compressor_tb
  import fsc_pkg::*;
;
  logic        ref_clk;
  logic        rst_b;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        batch_event;
  logic [15:0] sx;
  logic [15:0] sy;
  logic [15:0] sz;
  logic        cfg_change;
  logic [15:0] ts;
  logic        word_valid;
  fsc_tag_t    word_tag;
  logic [47:0] word_data;
  logic        fire;
  logic [15:0] step;
  logic [7:0]  rv;
  int          bad_count = 0;
  int          checks_done = 0;

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  fsc_compressor #(.AXIS_W(16)) fsc_compressor_i (.ref_clk, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .batch_event, .sample_x(sx), .sample_y(sy), .sample_z(sz),
    .cfg_change, .timestamp(ts), .word_valid, .word_tag, .word_data);

  fsc_sensor_model fsc_sensor_model_i (.ref_clk, .rst_b, .fire, .step, .batch_event,
    .sample_x(sx), .sample_y(sy), .sample_z(sz), .timestamp(ts), .word_valid, .word_tag,
    .word_data);

  function automatic int nn();
    return fsc_sensor_model_i.n;
  endfunction

  function automatic fsc_tag_t tg(int k);
    return fsc_sensor_model_i.log_tag[k];
  endfunction

  function automatic logic [47:0] dt(int k);
    return fsc_sensor_model_i.log_data[k];
  endfunction

  function automatic logic [47:0] cur();
    logic [15:0] b;
    b = fsc_sensor_model_i.base;
    return {b + 16'h0002, b + 16'h0001, b};
  endfunction

  function automatic int cnt(int lo, fsc_tag_t t);
    cnt = 0;
    for (int k = lo; k < nn(); k++)
      if (tg(k) === t)
        cnt++;
  endfunction

  task automatic chk(string what, logic [47:0] seen, logic [47:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(posedge ref_clk);
    rv = reg_rdata;
  endtask

  // events spaced ten cycles so a full flush drains before the next one
  task automatic slot();
    @(posedge ref_clk);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic restart(logic [7:0] c);
    wr(`FSC_ADDR_CTRL, 8'h00);
    slot();
    wr(`FSC_ADDR_CTRL, c);
    wr(`FSC_ADDR_INIT, 8'h01);
  endtask

  task automatic t_regs();
    rd(`FSC_ADDR_CTRL);
    chk("ctrl_reset", 48'(rv), 48'(`FSC_CTRL_RESET));
    wr(`FSC_ADDR_CTRL, 8'h1B);
    rd(`FSC_ADDR_CTRL);
    chk("ctrl_rw", 48'(rv), 48'h1B);
    rd(4'hF);
    chk("unmapped", 48'(rv), 48'h0);
    $display("done regs");
  endtask

  task automatic t_off();
    logic [7:0] c [3] = '{8'h00, 8'h01, 8'h02};
    int lo;
    foreach (c[k])
    begin
      wr(`FSC_ADDR_CTRL, c[k]);
      slot();
      lo = nn();
      slot();
      chk("off_count", 48'(nn() - lo), 48'h1);
      chk("off_tag", 48'(tg(lo)), 48'(FSC_TAG_PLAIN));
      chk("off_data", dt(lo), cur());
    end
    $display("done off");
  endtask

  task automatic t_comp(logic [15:0] s, fsc_tag_t t, logic [47:0] e);
    int lo;
    fsc_tag_t g;
    logic [47:0] d;
    step <= s;
    restart(8'h03);
    lo = nn();
    slot();
    chk("first_tag", 48'(tg(lo)), 48'(FSC_TAG_PLAIN));
    chk("first_data", dt(lo), cur());
    repeat (12) slot();
    for (int k = lo + 1; k < nn(); k++)
    begin
      g = tg(k);
      d = dt(k);
      chk("kind", 48'(g inside {FSC_TAG_PLAIN_T2, FSC_TAG_PAIR_DIFF, FSC_TAG_TRIPLE_DIFF}),
          48'h1);
      if (g === FSC_TAG_PLAIN_T2)
        chk("t2_axes", {d[47:32] - d[15:0], d[31:16] - d[15:0]}, 48'h0002_0001);
      else if (g === t)
        chk("diff_data", d, e);
    end
    chk("level", 48'(cnt(lo, t) > 0), 48'h1);
    $display("done comp %0d", s);
  endtask

  task automatic t_cfg();
    int lo;
    step <= 16'h0001;
    restart(8'h03);
    repeat (6) slot();
    lo = nn();
    @(posedge ref_clk);
    cfg_change <= 1'b1;
    @(posedge ref_clk);
    cfg_change <= 1'b0;
    slot();
    chk("cfg_first", 48'(tg(lo)), 48'(FSC_TAG_CFG_CHANGE));
    chk("cfg_ts", 48'(tg(lo + 1)), 48'(FSC_TAG_TIMESTAMP));
    chk("cfg_count", 48'(nn() - lo), 48'h5);
    chk("cfg_t2_tag", 48'(tg(lo + 2)), 48'(FSC_TAG_PLAIN_T2));
    chk("cfg_t2", dt(lo + 2), cur() - 48'h0002_0002_0002);
    chk("cfg_t1_tag", 48'(tg(lo + 3)), 48'(FSC_TAG_PLAIN_T1));
    chk("cfg_t1", dt(lo + 3), cur() - 48'h0001_0001_0001);
    chk("cfg_last", 48'(tg(nn() - 1)), 48'(FSC_TAG_PLAIN));
    chk("cfg_data", dt(nn() - 1), cur());
    lo = nn();
    repeat (6) slot();
    chk("resume", 48'(cnt(lo, FSC_TAG_TRIPLE_DIFF) > 0), 48'h1);
    wr(`FSC_ADDR_CTRL, 8'h07);
    slot();
    repeat (4)
    begin
      lo = nn();
      slot();
      chk("slot_ts", 48'(cnt(lo, FSC_TAG_TIMESTAMP)), 48'h1);
    end
    $display("done cfg");
  endtask

  task automatic t_rate();
    int lo;
    int p;
    int c;
    step <= 16'h0001;
    for (int r = 1; r < 4; r++)
    begin
      p = 4 << r;
      restart(8'h03 | 8'(r << 3));
      lo = nn();
      repeat (64) slot();
      c = cnt(lo, FSC_TAG_PLAIN_T2) + cnt(lo, FSC_TAG_PLAIN);
      chk("forced", 48'(c >= 64 / p - 1 && c <= 64 / p + 3), 48'h1);
    end
    $display("done rate");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cfg_change = 1'b0;
    fire = 1'b0;
    step = 16'h0001;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs();
    t_off();
    t_comp(16'h0001, FSC_TAG_TRIPLE_DIFF, 48'h0421_0421_0421);
    t_comp(16'h000F, FSC_TAG_TRIPLE_DIFF, 48'h3DEF_3DEF_3DEF);
    t_comp(16'h0010, FSC_TAG_PAIR_DIFF, 48'h1010_1010_1010);
    t_comp(16'h007F, FSC_TAG_PAIR_DIFF, 48'h7F7F_7F7F_7F7F);
    t_comp(16'h0081, FSC_TAG_PLAIN_T2, 48'h0);
    t_cfg();
    t_rate();
    complete_run();
  end
endmodule

// ### tb/fsc_sensor_model.sv
`timescale 1ns/1ps
module fsc_sensor_model
  import fsc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        fire,
  input  wire logic [15:0] step,
  output logic             batch_event,
  output logic      [15:0] sample_x,
  output logic      [15:0] sample_y,
  output logic      [15:0] sample_z,
  output logic      [15:0] timestamp,
  input  wire logic        word_valid,
  input  wire fsc_tag_t    word_tag,
  input  wire logic [47:0] word_data
);
  logic     [15:0] base;
  fsc_tag_t        log_tag [0:1023];
  logic     [47:0] log_data [0:1023];
  int              n = 0;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      base        <= 16'h0100;
      batch_event <= 1'b0;
      timestamp   <= 16'h0000;
    end
    else
    begin
      batch_event <= fire;
      timestamp   <= timestamp + 16'h0001;
      if (fire)
        base <= base + step;
    end
  end

  // off the pulse the lines show the inverse, so a late capture cannot pass by luck
  assign sample_x = batch_event ? base : ~base;
  assign sample_y = batch_event ? base + 16'h0001 : ~base;
  assign sample_z = batch_event ? base + 16'h0002 : ~base;

  // queue side keeps every word in write order
  always @(posedge ref_clk)
  begin
    if (word_valid === 1'b1)
    begin
      log_tag[n]  = word_tag;
      log_data[n] = word_data;
      n++;
    end
  end
endmodule
